//--- rtl/spm_port.sv
`timescale 1ns/1ns
`include "spm_consts.svh"

// Behaviour
// - Soft select manage set: internal select follows soft select level, pin free.
// - Slave phase 0: select low per byte; written while low gives collision.
// - Master drives SCK; data write loads shifter, sends MSB first on MOSI.
// - As master, master select and port enable stay set only while select is high.
// - Completed byte sets transfer complete; interrupt when enabled.
// - Master: complete flag clears by status access then data read.
// - Slave: complete flag clears by status access then data access.
// - Data writes ignored while complete flag set until status is accessed.
// - Slave clocks from SCK, shifts byte MSB first on MISO.
// - Polarity and phase choose capture edge; both ends must match.
// - Select low as master: mode fault, drop port enable and master.
// - Mode fault clears by status read then control write.
// - While mode fault, port enable and master cannot be set.
// - A slave never sets the mode fault flag.
// - Byte done with complete flag set: overrun, keep first byte.
// - Overrun clears when the status register is read.
// - Data write during transfer is dropped, sets collision, no interrupt.
// - SCK idles at the polarity level.
// - Phase 0 captures on first transition, phase 1 on second.
module spm_port #(
  parameter int HALF_NS = `SPM_HALF_NS
) (
  input  wire logic                  clock_i,
  input  wire logic                  srst_i,
  input  wire logic                  ce_i,
  input  wire logic                  sck_link_clk_i,
  input  wire logic                  ss_n_i,
  input  wire logic                  mosi_i,
  input  wire logic                  miso_i,
  input  wire logic                  ctrl_wr_i,
  input  wire spm_pkg::spm_ctrl_t    ctrl_wdata_i,
  input  wire logic                  csr_rd_i,
  input  wire logic                  csr_wr_i,
  input  wire spm_pkg::spm_sel_cfg_t csr_wdata_i,
  input  wire logic                  data_wr_i,
  input  wire logic [7:0]            data_wdata_i,
  input  wire logic                  data_rd_i,
  output spm_pkg::spm_ctrl_t         ctrl_o,
  output spm_pkg::spm_sel_cfg_t      sel_cfg_o,
  output spm_pkg::spm_status_t       status_o,
  output logic [7:0]                 rx_data_o,
  output logic                       irq_o,
  output spm_pkg::spm_pins_t         pin_o,
  output spm_pkg::spm_pins_t         pin_oe_o
);

  localparam int HALF_CYC_RAW = HALF_NS / `SPM_CLK_NS;
  localparam int HALF_CYC     = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;
  localparam int HW           = $clog2(HALF_CYC + 1);

  spm_pkg::spm_ctrl_t     ctrl_q;
  spm_pkg::spm_sel_cfg_t  sel_q;
  spm_pkg::spm_mst_state_t st_q;
  spm_pkg::spm_pins_t     oe_q;

  logic [HW-1:0] hcnt_q;
  logic [3:0]    edge_q;
  logic [7:0]    sh_q;
  logic [7:0]    tx_q;
  logic [7:0]    rx_q;
  logic          sck_q;
  logic          mosi_q;
  logic          irq_q;
  logic          transfer_complete_flag_q;
  logic          transfer_complete_flag_arm_q;
  logic          write_collision_flag_q;
  logic          write_collision_flag_arm_q;
  logic          ovr_q;
  logic          mode_fault_flag_q;
  logic          mode_fault_flag_arm_q;
  logic [3:0]    sync1_q;
  logic [3:0]    sync2_q;
  logic          tgl_prev_q;

  logic       lk_miso;
  logic [7:0] lk_rx;
  logic       lk_tgl;
  logic       lk_active;
  logic       link_rst;
  logic       ss_pin_s;
  logic       miso_s;
  logic       tgl_s;
  logic       act_s;
  logic       ss_int;
  logic       tick;
  logic       cap;
  logic       mst_done;
  logic       slv_done;
  logic       done_ev;
  logic       busy;
  logic       wr_ok;
  logic       wr_take;
  logic       write_collision_flag_set;
  logic       transfer_complete_flag_clr;
  logic       mode_fault_flag_ev;
  logic [7:0] sh_cap;

  // Pin and link-domain inputs pass two flip-flops. The done toggle keeps
  // crossing during reset, so no false completion follows its release.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sync1_q <= {2'h3, lk_tgl, 1'b0};
      sync2_q <= {2'h3, sync1_q[1], 1'b0};
    end else if (ce_i) begin
      sync1_q <= {ss_n_i, miso_i, lk_tgl, lk_active};
      sync2_q <= sync1_q;
    end
  end

  assign ss_pin_s = sync2_q[3];
  assign miso_s   = sync2_q[2];
  assign tgl_s    = sync2_q[1];
  assign act_s    = sync2_q[0];

  assign ss_int   = sel_q.soft_select_manage ? sel_q.soft_select_level
                                              : ss_pin_s;
  // The link shifter is held idle unless the port is an enabled slave with select low.
  assign link_rst = (sel_q.soft_select_manage ? sel_q.soft_select_level
                                               : ss_n_i)
                    | ctrl_q.master_select | ~ctrl_q.port_enable;

  spm_slave_link u_link (
    .sck_link_clk_i (sck_link_clk_i),
    .link_rst_i     (link_rst),
    .cpol_i         (ctrl_q.cpol),
    .cpha_i         (ctrl_q.cpha),
    .mosi_i         (mosi_i),
    .tx_i           (tx_q),
    .miso_o         (lk_miso),
    .rx_word_o      (lk_rx),
    .done_tgl_o     (lk_tgl),
    .active_o       (lk_active)
  );

  assign tick     = (hcnt_q == HW'(HALF_CYC - 1));
  assign cap      = (edge_q[0] == ctrl_q.cpha);
  assign sh_cap   = cap ? {sh_q[6:0], miso_s} : sh_q;
  assign mst_done = (st_q == spm_pkg::SPM_RUN) && tick
                    && (edge_q == `SPM_LAST_EDGE);
  assign slv_done = (tgl_s ^ tgl_prev_q) && ctrl_q.port_enable
                    && !ctrl_q.master_select;
  assign done_ev  = mst_done | slv_done;
  assign mode_fault_flag_ev  = ctrl_q.master_select && !ss_int;

  // Slave with phase 0 is busy whenever selected; phase 1 only mid-byte.
  assign busy     = ctrl_q.master_select ? (st_q == spm_pkg::SPM_RUN)
                    : (ctrl_q.port_enable
                       && (ctrl_q.cpha ? act_s : !ss_int));
  assign wr_ok    = !transfer_complete_flag_q || transfer_complete_flag_arm_q;
  assign wr_take  = data_wr_i && wr_ok && !busy;
  assign write_collision_flag_set = data_wr_i && wr_ok && busy;
  assign transfer_complete_flag_clr = transfer_complete_flag_arm_q && (data_rd_i
                    || (!ctrl_q.master_select && data_wr_i));

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tgl_prev_q <= tgl_s;
    end else if (ce_i) begin
      tgl_prev_q <= tgl_s;
    end
  end

  // Control register, with hardware clearing on a mode fault.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl_q <= `SPM_CTRL_RST;
    end else if (ce_i) begin
      if (ctrl_wr_i) begin
        ctrl_q <= ctrl_wdata_i;
      end
      if (mode_fault_flag_ev) begin
        ctrl_q.port_enable   <= 1'b0;
        ctrl_q.master_select <= 1'b0;
      end else if (ctrl_wr_i && mode_fault_flag_q && !mode_fault_flag_arm_q) begin
        ctrl_q.port_enable   <= 1'b0;
        ctrl_q.master_select <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sel_q <= `SPM_SEL_RST;
    end else if (ce_i && csr_wr_i) begin
      sel_q <= csr_wdata_i;
    end
  end

  // Master engine: a half-period counter paces SCK edges.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_q   <= spm_pkg::SPM_IDLE;
      hcnt_q <= '0;
      edge_q <= 4'h0;
      sh_q   <= `SPM_BYTE_RST;
      sck_q  <= 1'b0;
      mosi_q <= 1'b0;
    end else if (ce_i) begin
      case (st_q)
        spm_pkg::SPM_IDLE: begin
          sck_q  <= ctrl_q.cpol;
          hcnt_q <= '0;
          edge_q <= 4'h0;
          if (wr_take && ctrl_q.master_select && ctrl_q.port_enable) begin
            st_q <= spm_pkg::SPM_RUN;
            sh_q <= data_wdata_i;
            if (!ctrl_q.cpha) begin
              mosi_q <= data_wdata_i[7];
            end
          end
        end
        spm_pkg::SPM_RUN: begin
          if (mode_fault_flag_ev) begin
            st_q <= spm_pkg::SPM_IDLE;
          end else if (tick) begin
            hcnt_q <= '0;
            sck_q  <= ~sck_q;
            edge_q <= edge_q + 4'h1;
            sh_q   <= sh_cap;
            if (!cap) begin
              mosi_q <= sh_q[7];
            end
            if (edge_q == `SPM_LAST_EDGE) begin
              st_q <= spm_pkg::SPM_IDLE;
            end
          end else begin
            hcnt_q <= hcnt_q + HW'(1);
          end
        end
        default: begin
          st_q <= spm_pkg::SPM_IDLE;
        end
      endcase
    end
  end

  // Byte offered to the slave shifter; stable while the link uses it.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tx_q <= `SPM_BYTE_RST;
    end else if (ce_i && wr_take) begin
      tx_q <= data_wdata_i;
    end
  end

  // Receive buffer keeps the first byte after the flag was cleared.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rx_q <= `SPM_BYTE_RST;
    end else if (ce_i && done_ev && !transfer_complete_flag_q) begin
      rx_q <= mst_done ? sh_cap : lk_rx;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      transfer_complete_flag_q     <= 1'b0;
      transfer_complete_flag_arm_q <= 1'b0;
    end else if (ce_i) begin
      transfer_complete_flag_q     <= done_ev | (transfer_complete_flag_q & ~transfer_complete_flag_clr);
      transfer_complete_flag_arm_q <= (transfer_complete_flag_arm_q | ((csr_rd_i | csr_wr_i) & transfer_complete_flag_q))
                    & ~transfer_complete_flag_clr & ~done_ev;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ovr_q <= 1'b0;
    end else if (ce_i) begin
      ovr_q <= (done_ev & transfer_complete_flag_q) | (ovr_q & ~csr_rd_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      write_collision_flag_q     <= 1'b0;
      write_collision_flag_arm_q <= 1'b0;
    end else if (ce_i) begin
      if (write_collision_flag_set) begin
        write_collision_flag_q     <= 1'b1;
        write_collision_flag_arm_q <= 1'b0;
      end else if (write_collision_flag_arm_q && (data_rd_i || data_wr_i)) begin
        write_collision_flag_q     <= 1'b0;
        write_collision_flag_arm_q <= 1'b0;
      end else if (csr_rd_i && write_collision_flag_q) begin
        write_collision_flag_arm_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mode_fault_flag_q     <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end else if (ce_i) begin
      if (mode_fault_flag_ev) begin
        mode_fault_flag_q     <= 1'b1;
        mode_fault_flag_arm_q <= 1'b0;
      end else if (mode_fault_flag_arm_q && ctrl_wr_i) begin
        mode_fault_flag_q     <= 1'b0;
        mode_fault_flag_arm_q <= 1'b0;
      end else if (csr_rd_i && mode_fault_flag_q) begin
        mode_fault_flag_arm_q <= 1'b1;
      end
    end
  end

  // Collision never raises the request line.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= ctrl_q.serial_irq_enable & (transfer_complete_flag_q | mode_fault_flag_q | ovr_q);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      oe_q <= 3'h0;
    end else if (ce_i) begin
      oe_q.sck  <= ctrl_q.port_enable & ctrl_q.master_select;
      oe_q.mosi <= ctrl_q.port_enable & ctrl_q.master_select;
      oe_q.miso <= ctrl_q.port_enable & ~ctrl_q.master_select & ~ss_int;
    end
  end

  assign ctrl_o    = ctrl_q;
  assign sel_cfg_o = sel_q;
  assign status_o  = {transfer_complete_flag_q, write_collision_flag_q, ovr_q, mode_fault_flag_q};
  assign rx_data_o = rx_q;
  assign irq_o     = irq_q;
  assign pin_o     = {sck_q, mosi_q, lk_miso};
  assign pin_oe_o  = oe_q;

  default clocking dc @(posedge clock_i); endclocking
  default disable iff (srst_i);

  mode_fault_flag_sets_a: assert property (ce_i && mode_fault_flag_ev |=> mode_fault_flag_q
      && !ctrl_q.port_enable && !ctrl_q.master_select)
    else $error("mode fault did not drop master and port enable");
  slave_no_mode_fault_flag_a: assert property (!ctrl_q.master_select && !mode_fault_flag_q
      |=> !mode_fault_flag_q)
    else $error("slave raised mode fault");
  done_transfer_complete_flag_a: assert property (ce_i && done_ev |=> transfer_complete_flag_q)
    else $error("completed byte did not set complete flag");
  ovr_keep_a: assert property (ce_i && done_ev && transfer_complete_flag_q
      |=> ovr_q && $stable(rx_q))
    else $error("overrun not flagged or buffer overwritten");
  ovr_clear_a: assert property (ce_i && csr_rd_i && !done_ev
      |=> !ovr_q)
    else $error("overrun survived status read");
  write_collision_flag_set_a: assert property (ce_i && data_wr_i && wr_ok && busy
      |=> write_collision_flag_q && $stable(tx_q))
    else $error("collision not flagged or write taken");
  transfer_complete_flag_hold_a: assert property (transfer_complete_flag_q && !transfer_complete_flag_arm_q
      |=> transfer_complete_flag_q)
    else $error("complete flag cleared without status access");
  wr_block_a: assert property (transfer_complete_flag_q && !transfer_complete_flag_arm_q && data_wr_i
      |=> $stable(tx_q) && !write_collision_flag_q || $past(write_collision_flag_q))
    else $error("data write taken while complete flag set");
  mode_fault_flag_lock_a: assert property (mode_fault_flag_q && !mode_fault_flag_arm_q
      |=> !ctrl_q.port_enable && !ctrl_q.master_select)
    else $error("enable set during mode fault");
  sck_idle_a: assert property (st_q == spm_pkg::SPM_IDLE && ce_i
      ##1 $stable(ctrl_q.cpol) |-> pin_o.sck == ctrl_q.cpol)
    else $error("serial clock not at idle level");
  master_len_a: assert property (st_q == spm_pkg::SPM_IDLE && ce_i
      ##1 st_q == spm_pkg::SPM_RUN && hcnt_q == '0 && edge_q == 4'h0
      |-> ##[1:300] transfer_complete_flag_q || mode_fault_flag_q || !ce_i)
    else $error("master byte did not complete");

  master_done_c: cover property (mst_done);
  slave_done_c: cover property (slv_done);
  mode_fault_c: cover property (mode_fault_flag_ev);
  overrun_c: cover property (done_ev && transfer_complete_flag_q);

endmodule : spm_port

//--- shared/spm_consts.svh
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

// Shift register length and index of the last serial clock edge of a byte.
`define SPM_BITS        8
`define SPM_LAST_EDGE   4'hF
// System clock period and default serial half period in nanoseconds.
`define SPM_CLK_NS      40
`define SPM_HALF_NS     160
// Reset values of the software visible state.
`define SPM_BYTE_RST    8'h00
`define SPM_CTRL_RST    5'h00
`define SPM_SEL_RST     2'h0

`endif

//--- shared/spm_pkg.sv
package spm_pkg;

  typedef struct packed {
    logic serial_irq_enable;
    logic port_enable;
    logic master_select;
    logic cpol;
    logic cpha;
  } spm_ctrl_t;

  typedef struct packed {
    logic soft_select_manage;
    logic soft_select_level;
  } spm_sel_cfg_t;

  typedef struct packed {
    logic transfer_complete_flag;
    logic write_collision_flag;
    logic overrun_flag;
    logic mode_fault_flag;
  } spm_status_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
  } spm_pins_t;

  typedef enum logic {
    SPM_IDLE,
    SPM_RUN
  } spm_mst_state_t;

endpackage : spm_pkg

//--- rtl/spm_slave_link.sv
`timescale 1ns/1ns
`include "spm_consts.svh"

// Slave shifter clocked by the serial clock pin. The capture edge is the
// rising edge of the polarity and phase corrected clock.
module spm_slave_link (
  input  wire logic       sck_link_clk_i,
  input  wire logic       link_rst_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic [7:0]      rx_word_o,
  output logic            done_tgl_o,
  output logic            active_o
);

  logic       cap_clk;
  logic [2:0] cnt_q;
  logic [7:0] rx_sh_q;
  logic       out_q;
  logic       done_tgl_q = 1'b0;
  logic [7:0] rx_word_q = `SPM_BYTE_RST;
  logic       active_q;

  assign cap_clk = sck_link_clk_i ^ cpol_i ^ cpha_i;

  always_ff @(posedge cap_clk or posedge link_rst_i) begin
    if (link_rst_i) begin
      cnt_q    <= 3'h0;
      rx_sh_q  <= `SPM_BYTE_RST;
      active_q <= 1'b0;
    end else begin
      cnt_q    <= cnt_q + 3'h1;
      rx_sh_q  <= {rx_sh_q[6:0], mosi_i};
      active_q <= (cnt_q != 3'h7);
    end
  end

  // The finished byte and its event toggle survive deselection.
  always_ff @(posedge cap_clk) begin
    if (!link_rst_i && cnt_q == 3'h7) begin
      rx_word_q  <= {rx_sh_q[6:0], mosi_i};
      done_tgl_q <= ~done_tgl_q;
    end
  end

  always_ff @(negedge cap_clk or posedge link_rst_i) begin
    if (link_rst_i) begin
      out_q <= 1'b0;
    end else begin
      out_q <= tx_i[3'h7 - cnt_q];
    end
  end

  // With phase 0 the first bit must stand before the first edge.
  assign miso_o     = (!cpha_i && cnt_q == 3'h0) ? tx_i[7] : out_q;
  assign rx_word_o  = rx_word_q;
  assign done_tgl_o = done_tgl_q;
  assign active_o   = active_q;

endmodule : spm_slave_link

//--- tb/spm_far_end.sv
`timescale 1ns/1ns

// Far side: a slave that answers the port as master, and a master whose
// 32 ns serial clock runs only inside its frames.
module spm_far_end (
  input  wire logic sck_i,
  input  wire logic mosi_i,
  input  wire logic miso_i,
  input  wire logic cpol_i,
  input  wire logic cpha_i,
  output logic      miso_o,
  output logic      mosi_o,
  output logic      sck_o,
  output logic      ss_n_o
);
  logic [8:0] sh;
  logic [7:0] got;
  wire        cap = sck_i ^ cpol_i ^ cpha_i;

  initial begin
    sh = 9'h000;
    got = 8'h00;
    sck_o = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
  end

  always @(posedge cap) got <= {got[6:0], mosi_i};
  // Fresh inverted bits leave the line once the byte is out.
  always @(negedge cap) sh <= {sh[7:0], ~sh[0]};
  assign miso_o = sh[8];

  // Phase 1 loses one launch edge before the first capture.
  task automatic load(input logic [7:0] v);
    sh = cpha_i ? {~v[7], v} : {v, ~v[0]};
  endtask : load

  task automatic mxfer(input logic [7:0] b, output logic [7:0] r);
    sck_o = cpol_i;
    #20 ss_n_o = 1'b0;
    // The port enables its MISO driver a few system clocks after select.
    #160;
    for (int i = 7; i >= 0; i--) begin
      if (!cpha_i) mosi_o = b[i];
      #16 sck_o = ~sck_o;
      if (cpha_i) mosi_o = b[i];
      else r[i] = miso_i;
      #16 sck_o = ~sck_o;
      if (cpha_i) r[i] = miso_i;
    end
    #16 ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask : mxfer
endmodule : spm_far_end

//--- tb/spm_port_tb_top.sv
`timescale 1ns/1ns

module spm_port_tb_top;
  logic                  clock_i;
  logic                  srst_i;
  logic [4:0]            stb;
  logic [7:0]            wd;
  logic                  ss_low;
  logic                  cpol;
  logic                  cpha;
  logic [7:0]            d;
  logic [7:0]            s;
  logic [7:0]            r;
  logic                  m_miso;
  logic                  m_mosi;
  logic                  m_sck;
  logic                  m_ss_n;
  spm_pkg::spm_ctrl_t    ctrl;
  spm_pkg::spm_sel_cfg_t sel;
  spm_pkg::spm_status_t  st;
  logic [7:0]            rx;
  logic                  irq;
  spm_pkg::spm_pins_t    pin;
  spm_pkg::spm_pins_t    oe;
  int                    n_fail = 0;
  int                    comparisons = 0;

  spm_port #(.HALF_NS(160)) dut (
    .clock_i(clock_i), .srst_i(srst_i), .ce_i(1'b1),
    .sck_link_clk_i(m_sck), .ss_n_i(m_ss_n & ~ss_low),
    .mosi_i(m_mosi), .miso_i(m_miso), .ctrl_wr_i(stb[0]),
    .ctrl_wdata_i(spm_pkg::spm_ctrl_t'(wd[4:0])), .csr_rd_i(stb[1]),
    .csr_wr_i(stb[2]), .csr_wdata_i(spm_pkg::spm_sel_cfg_t'(wd[1:0])),
    .data_wr_i(stb[3]), .data_wdata_i(wd), .data_rd_i(stb[4]),
    .ctrl_o(ctrl), .sel_cfg_o(sel), .status_o(st), .rx_data_o(rx),
    .irq_o(irq), .pin_o(pin), .pin_oe_o(oe));

  // An undriven MISO line shows the inverse of what the port puts out.
  spm_far_end mdl (
    .sck_i(pin.sck), .mosi_i(pin.mosi),
    .miso_i(oe.miso ? pin.miso : ~pin.miso),
    .cpol_i(cpol), .cpha_i(cpha), .miso_o(m_miso), .mosi_o(m_mosi),
    .sck_o(m_sck), .ss_n_o(m_ss_n));

  always #20 clock_i = ~clock_i;

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask : cyc

  // Strobe index: 0 ctrl write, 1 status read, 2 select write,
  // 3 data write, 4 data read.
  task automatic acc(input int k, input logic [7:0] v);
    wd = v;
    stb[k] = 1'b1;
    cyc(1);
    stb = 5'h00;
    cyc(1);
  endtask : acc

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wait_done();
    int i;
    i = 0;
    while (st.transfer_complete_flag !== 1'b1 && i < 300) begin
      cyc(1);
      i++;
    end
    if (i >= 300) begin
      n_fail++;
      $display("ERROR %0t transfer never completed", $time);
    end
  endtask : wait_done

  task automatic wrap_up();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #800000;
    n_fail++;
    wrap_up();
  end

  initial begin
    clock_i = 1'b0;
    srst_i = 1'b1;
    stb = 5'h00;
    wd = 8'h00;
    ss_low = 1'b0;
    cpol = 1'b0;
    cpha = 1'b0;
    void'($urandom(32'h01552362));
    repeat (4) @(posedge clock_i);
    #2 srst_i = 1'b0;
    cyc(1);
    chk({ctrl, sel, irq}, 8'h00);
    chk(8'(st), 8'h00);
    chk(rx, 8'h00);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      cpol = k[1];
      cpha = k[0];
      acc(0, 8'h00);
      acc(2, 8'h03);
      acc(0, 8'h1C | 8'(k));
      cyc(4);
      chk({oe.sck, pin.sck}, {1'b1, cpol});
      chk(8'(ctrl), 8'h1C | 8'(k));
      s = 8'($urandom);
      d = 8'($urandom);
      mdl.load(s);
      acc(3, d);
      cyc(10);
      acc(3, ~d);
      wait_done();
      cyc(2);
      chk(rx, s);
      chk(mdl.got, d);
      chk(8'(st), 8'h0C);
      chk(8'(irq), 8'h01);
      acc(3, 8'h5A);
      cyc(20);
      chk({oe.sck, pin.sck}, {1'b1, cpol});
      acc(1, 8'h00);
      chk(8'(st), 8'h0C);
      acc(4, 8'h00);
      chk(8'(st), 8'h00);
    end
    $display("master test done");
    acc(2, 8'h00);
    for (int k = 0; k < 4; k++) begin
      cpol = k[1];
      cpha = k[0];
      acc(0, 8'h00);
      acc(0, 8'h08 | 8'(k));
      s = 8'($urandom);
      d = 8'($urandom);
      acc(3, s);
      mdl.mxfer(d, r);
      wait_done();
      cyc(2);
      chk(rx, d);
      chk(r, s);
      chk({st, 3'h0, irq}, 8'h80);
      mdl.mxfer(~d, r);
      cyc(8);
      chk(8'(st), 8'h0A);
      chk(rx, d);
      acc(1, 8'h00);
      chk(8'(st), 8'h08);
      acc(3, 8'h00);
      chk(8'(st), 8'h00);
    end
    $display("slave test done");
    cpol = 1'b0;
    cpha = 1'b0;
    acc(0, 8'h00);
    acc(0, 8'h18);
    ss_low = 1'b1;
    cyc(4);
    acc(3, 8'hA5);
    cyc(2);
    chk({st, 3'h0, irq}, 8'h40);
    chk(8'(oe), 8'h01);
    ss_low = 1'b0;
    cyc(4);
    acc(1, 8'h00);
    acc(4, 8'h00);
    chk(8'(st), 8'h00);
    $display("collision test done");
    acc(0, 8'h00);
    acc(2, 8'h03);
    acc(0, 8'h1C);
    ss_low = 1'b1;
    cyc(6);
    chk(8'(st), 8'h00);
    chk(8'(ctrl), 8'h1C);
    acc(2, 8'h00);
    cyc(6);
    chk({st, 3'h0, irq}, 8'h11);
    chk(8'(ctrl), 8'h10);
    chk(8'(oe), 8'h00);
    ss_low = 1'b0;
    cyc(4);
    acc(0, 8'h1C);
    chk(8'(ctrl), 8'h10);
    chk(8'(st), 8'h01);
    acc(1, 8'h00);
    acc(0, 8'h1C);
    chk(8'(st), 8'h00);
    chk(8'(ctrl), 8'h1C);
    $display("fault test done");
    wrap_up();
  end
endmodule : spm_port_tb_top
